// >>> logic/wrs_defines.svh
// Constants of the watchdog, reset and interrupt status block.
// Assumes ref_clk runs at 40 MHz and osc_tick pulses once per millisecond.
`ifndef WRS_DEFINES_SVH
`define WRS_DEFINES_SVH

`define WRS_CLK_PERIOD_NS   25
`define WRS_ADDR_WD         3'h0
`define WRS_ADDR_INT_STATUS 3'h3
`define WRS_INT_ADDR_HI     15
`define WRS_INT_ADDR_LO     13
`define WRS_INT_LOCK        12
`define WRS_INT_MAIN_LOW    11
`define WRS_INT_CAN_LOW     10
`define WRS_INT_CYCLIC      7
`define WRS_INT_WAKE1       6
`define WRS_INT_POWER_ON    5
`define WRS_INT_WAKE2       4
`define WRS_INT_BUS_WAKE    3
`define WRS_FLAG_MASK       16'h0CF8
`define WRS_INT_RESET_VAL   16'h0020
`define WRS_WD_MODE_SEL     8
`define WRS_WD_PER_HI       7
`define WRS_WD_PER_LO       5
`define WRS_WD_SOFT_RST     4
`define WRS_PERIOD_DEFAULT  3'h4
`define WRS_PERIOD_BASE_MS  16'h0008
`define WRS_FLTR_NS         1000
`define WRS_FLTR_CYC        ((`WRS_FLTR_NS + `WRS_CLK_PERIOD_NS - 1) / `WRS_CLK_PERIOD_NS)
`define WRS_SHORT_RST_US    1000
`define WRS_LONG_RST_US     20000
`define WRS_SLEEP_CODE      2'h1

`endif

// >>> logic/wrs_pkg.sv
// Types shared by the watchdog, reset and interrupt status block.
// Assumes nothing of its surroundings.
package wrs_pkg;
	typedef enum logic [1:0] {WRS_WD_OFF, WRS_WD_WINDOW, WRS_WD_TIMEOUT} wrs_wd_mode_t;
	typedef enum logic [1:0] {WRS_RP_IDLE, WRS_RP_DRIVE, WRS_RP_EXT} wrs_rp_state_t;
endpackage

// >>> logic/wrs_timer.sv
// Watchdog period timer counting oscillator ticks.
// Assumes osc_tick is a one-cycle pulse in the ref_clk domain.
`timescale 1ns/10ps
module wrs_timer #(
	parameter int W = 16
) (
	input  wire logic         ref_clk,
	input  wire logic         arst_n,
	input  wire logic         run,
	input  wire logic         restart,
	input  wire logic         osc_tick,
	input  wire logic [W-1:0] period_ticks,
	output logic              open_win,
	output logic              overflow
);
	logic [W-1:0] cnt_r;

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			cnt_r <= '0;
		end else if (!run || restart || overflow) begin
			cnt_r <= '0;
		end else if (osc_tick) begin
			cnt_r <= cnt_r + {{(W-1){1'b0}}, 1'b1};
		end
	end

	// First trigger time is half the period, overflow at the full period
	assign open_win = cnt_r >= (period_ticks >> 1);
	// Kept free of restart: restart depends on the system reset that overflow raises
	assign overflow = run && (cnt_r >= period_ticks);
endmodule

// >>> logic/wrs_top.sv
// Watchdog, system reset manager and interrupt status register.
// Assumes an SPI front end delivering decoded register strobes, and
// synchronous pin levels. The reset line is open drain.
`timescale 1ns/10ps
`include "wrs_defines.svh"
module wrs_top import wrs_pkg::*; #(
	parameter int SHORT_RST_CYC = `WRS_SHORT_RST_US * 1000 / `WRS_CLK_PERIOD_NS,
	parameter int LONG_RST_CYC  = `WRS_LONG_RST_US * 1000 / `WRS_CLK_PERIOD_NS,
	parameter int CNT_W         = 24
) (
	input  wire logic        ref_clk,
	input  wire logic        arst_n,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	input  wire logic [2:0]  reg_addr_bits,
	input  wire logic [15:0] reg_wdata,
	output logic      [15:0] reg_rdata,
	input  wire logic [1:0]  chip_mode_code,
	input  wire logic        overtemp_mode,
	input  wire logic        sleep_req,
	output logic             sleep_grant,
	input  wire logic        wd_disable_pin,
	input  wire logic        fail_safe_output_ctrl,
	input  wire logic        can_lowpower_ctrl,
	input  wire logic [1:0]  wake1_irq_cfg,
	input  wire logic [1:0]  wake2_irq_cfg,
	input  wire logic        irq_line_n,
	input  wire logic        main_low_evt,
	input  wire logic        can_low_evt,
	input  wire logic        wake1_evt,
	input  wire logic        wake2_evt,
	input  wire logic        bus_wake_evt,
	input  wire logic        main_uv_rst_evt,
	input  wire logic        mode_exit_rst_evt,
	input  wire logic        osc_tick,
	input  wire logic        short_rst_strap,
	input  wire logic        reset_line_n_i,
	output logic             reset_line_n_o,
	output logic             reset_line_n_oe,
	output logic             sys_reset_pulse,
	output logic             fail_safe_en,
	output logic [1:0]       wd_mode_state
);
	logic [15:0]        int_status_r;
	logic               lock_r;
	logic [2:0]         period_sel_r;
	logic               mode_sel_r;
	logic               dis_pin_r;
	logic               strap_r;
	logic               strap_done_r;
	logic               en_block_r;
	logic [15:0]        rdata_r;
	logic               sleep_grant_r;
	wrs_rp_state_t      rp_state_r;
	logic [CNT_W-1:0]   rp_cnt_r;
	wrs_wd_mode_t       wd_mode;
	wrs_wd_mode_t       wd_mode_r;
	logic               normal_mode;
	logic               standby_mode;
	logic               any_pending;
	logic               wake_pending;
	logic               wd_wr;
	logic               int_wr;
	logic               open_win;
	logic               overflow;
	logic [15:0]        period_ticks;
	logic               mode_sel_wr;
	logic               wd_rst;
	logic               long_rst;
	logic               int_rst;
	logic               ext_rst;
	logic               sleep_bad;
	logic [15:0]        set_vec;
	logic [15:0]        clr_vec;

	// Mode decode
	assign normal_mode  = chip_mode_code[1];
	assign standby_mode = !chip_mode_code[1] && (chip_mode_code != `WRS_SLEEP_CODE) && !overtemp_mode;
	assign any_pending  = |(int_status_r & `WRS_FLAG_MASK);
	assign wake_pending = int_status_r[`WRS_INT_WAKE1] | int_status_r[`WRS_INT_WAKE2] |
	                      int_status_r[`WRS_INT_BUS_WAKE];
	assign wd_wr        = reg_wr && (reg_addr_bits == `WRS_ADDR_WD);
	assign int_wr       = reg_wr && (reg_addr_bits == `WRS_ADDR_INT_STATUS);

	always_comb begin
		wd_mode = WRS_WD_OFF;
		if (wd_disable_pin || overtemp_mode) begin
			wd_mode = WRS_WD_OFF;
		end else if (normal_mode) begin
			wd_mode = mode_sel_r ? WRS_WD_TIMEOUT : WRS_WD_WINDOW;
		end else if (standby_mode) begin
			if (!mode_sel_r || any_pending) begin
				wd_mode = WRS_WD_TIMEOUT;
			end
		end
	end
	assign wd_mode_state = wd_mode_r;

	// Period in ms ticks: code 100 selects 128
	assign period_ticks = `WRS_PERIOD_BASE_MS << period_sel_r;

	wrs_timer #(.W(16)) u_timer (
		.ref_clk      (ref_clk),
		.arst_n       (arst_n),
		.run          (wd_mode != WRS_WD_OFF),
		.restart      (wd_wr || (wd_mode != wd_mode_r) || sys_reset_pulse),
		.osc_tick     (osc_tick),
		.period_ticks (period_ticks),
		.open_win     (open_win),
		.overflow     (overflow)
	);

	// Reset causes
	assign mode_sel_wr = wd_wr && (reg_wdata[`WRS_WD_MODE_SEL] != mode_sel_r) &&
	                     !(standby_mode && any_pending);
	assign sleep_bad   = !irq_line_n ||
	                     (!can_lowpower_ctrl && (wake1_irq_cfg == 2'h0) && (wake2_irq_cfg == 2'h0)) ||
	                     wake_pending;
	always_comb begin
		wd_rst = 1'b0;
		if (wd_mode == WRS_WD_WINDOW && wd_wr && !open_win) begin
			wd_rst = 1'b1;
		end else if (wd_mode == WRS_WD_WINDOW && overflow) begin
			wd_rst = 1'b1;
		end else if (wd_mode == WRS_WD_TIMEOUT && overflow && int_status_r[`WRS_INT_CYCLIC]) begin
			wd_rst = 1'b1;
		end else if ((normal_mode || standby_mode) && (wd_disable_pin != dis_pin_r)) begin
			wd_rst = 1'b1;
		end else if (normal_mode && mode_sel_wr) begin
			wd_rst = 1'b1;
		end
	end
	assign long_rst = (main_uv_rst_evt || mode_exit_rst_evt) && !strap_r;
	assign int_rst  = wd_rst || long_rst || main_uv_rst_evt || mode_exit_rst_evt ||
	                  (wd_wr && reg_wdata[`WRS_WD_SOFT_RST]) ||
	                  (sleep_req && sleep_bad);
	assign ext_rst  = (rp_state_r == WRS_RP_IDLE) && !reset_line_n_i &&
	                  (rp_cnt_r >= CNT_W'(`WRS_FLTR_CYC - 1));

	// Strap caught once after reset release, default long
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			strap_r      <= 1'b0;
			strap_done_r <= 1'b0;
		end else if (!strap_done_r) begin
			strap_r      <= short_rst_strap;
			strap_done_r <= 1'b1;
		end
	end

	// Reset line: filter external low, drive internal pulses
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			rp_state_r <= WRS_RP_IDLE;
			rp_cnt_r   <= '0;
		end else begin
			case (rp_state_r)
				WRS_RP_IDLE: begin
					if (int_rst) begin
						rp_state_r <= WRS_RP_DRIVE;
						rp_cnt_r   <= long_rst ? CNT_W'(LONG_RST_CYC - 1) : CNT_W'(SHORT_RST_CYC - 1);
					end else if (ext_rst) begin
						rp_state_r <= WRS_RP_EXT;
						rp_cnt_r   <= '0;
					end else if (!reset_line_n_i) begin
						rp_cnt_r <= rp_cnt_r + CNT_W'(1);
					end else begin
						rp_cnt_r <= '0;
					end
				end
				WRS_RP_DRIVE: begin
					if (long_rst) begin
						rp_cnt_r <= CNT_W'(LONG_RST_CYC - 1);
					end else if (rp_cnt_r == '0) begin
						rp_state_r <= WRS_RP_EXT;
					end else begin
						rp_cnt_r <= rp_cnt_r - CNT_W'(1);
					end
				end
				WRS_RP_EXT: begin
					if (reset_line_n_i) begin
						rp_state_r <= WRS_RP_IDLE;
						rp_cnt_r   <= '0;
					end
				end
				default: begin
					rp_state_r <= WRS_RP_IDLE;
					rp_cnt_r   <= '0;
				end
			endcase
		end
	end
	assign reset_line_n_o  = 1'b0;
	assign reset_line_n_oe = (rp_state_r == WRS_RP_DRIVE);
	assign sys_reset_pulse = (rp_state_r == WRS_RP_IDLE) && (int_rst || ext_rst);

	// Watchdog control fields
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			period_sel_r <= `WRS_PERIOD_DEFAULT;
			mode_sel_r   <= 1'b0;
			dis_pin_r    <= 1'b0;
			wd_mode_r    <= WRS_WD_OFF;
		end else begin
			dis_pin_r <= wd_disable_pin;
			wd_mode_r <= wd_mode;
			if (wd_rst) begin
				period_sel_r <= `WRS_PERIOD_DEFAULT;
			end else if (wd_wr) begin
				period_sel_r <= reg_wdata[`WRS_WD_PER_HI:`WRS_WD_PER_LO];
			end
			if (mode_sel_wr) begin
				mode_sel_r <= reg_wdata[`WRS_WD_MODE_SEL];
			end
		end
	end

	// Interrupt flags: set wins over clear
	always_comb begin
		set_vec = 16'h0000;
		set_vec[`WRS_INT_MAIN_LOW] = main_low_evt;
		set_vec[`WRS_INT_CAN_LOW]  = can_low_evt;
		set_vec[`WRS_INT_CYCLIC]   = (wd_mode == WRS_WD_TIMEOUT) && overflow;
		set_vec[`WRS_INT_WAKE1]    = wake1_evt && (wake1_irq_cfg != 2'h0);
		set_vec[`WRS_INT_WAKE2]    = wake2_evt && (wake2_irq_cfg != 2'h0);
		set_vec[`WRS_INT_BUS_WAKE] = bus_wake_evt && can_lowpower_ctrl;
		set_vec[`WRS_INT_POWER_ON] = mode_exit_rst_evt;
		clr_vec = (int_wr && !lock_r) ? (reg_wdata & `WRS_FLAG_MASK) : 16'h0000;
	end

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			int_status_r <= `WRS_INT_RESET_VAL;
		end else begin
			int_status_r <= ((int_status_r & ~clr_vec) | set_vec) & `WRS_FLAG_MASK;
		end
	end

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			lock_r <= 1'b0;
		end else if (int_wr) begin
			lock_r <= reg_wdata[`WRS_INT_LOCK];
		end
	end

	// Read data
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			rdata_r <= 16'h0000;
		end else if (reg_rd) begin
			if (reg_addr_bits == `WRS_ADDR_INT_STATUS) begin
				rdata_r <= int_status_r;
				rdata_r[`WRS_INT_ADDR_HI:`WRS_INT_ADDR_LO] <= `WRS_ADDR_INT_STATUS;
				rdata_r[`WRS_INT_LOCK] <= lock_r;
			end else if (reg_addr_bits == `WRS_ADDR_WD) begin
				rdata_r <= 16'h0000;
				rdata_r[`WRS_WD_MODE_SEL] <= mode_sel_r;
				rdata_r[`WRS_WD_PER_HI:`WRS_WD_PER_LO] <= period_sel_r;
			end else begin
				rdata_r <= 16'h0000;
			end
		end
	end
	assign reg_rdata = rdata_r;

	// Sleep acceptance and fail-safe output
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			sleep_grant_r <= 1'b0;
			en_block_r    <= 1'b1;
		end else begin
			sleep_grant_r <= sleep_req && !sleep_bad;
			if (sys_reset_pulse || rp_state_r != WRS_RP_IDLE) begin
				en_block_r <= 1'b1;
			end else if (!fail_safe_output_ctrl) begin
				en_block_r <= 1'b0;
			end
		end
	end
	assign sleep_grant  = sleep_grant_r;
	assign fail_safe_en = fail_safe_output_ctrl && normal_mode && !en_block_r;
endmodule

// >>> test/wrs_mcu_model.sv
// Microcontroller side of the open-drain reset wire, with its pull-up.
// Assumes the bench raises hold_req to pull the wire low.
`timescale 1ns/10ps
module wrs_mcu_model (
	input  wire logic reset_line_n_o,
	input  wire logic reset_line_n_oe,
	input  wire logic hold_req,
	output logic      wire_n
);
	// Pull-up wins only when no party pulls low
	assign wire_n = !(hold_req || (reset_line_n_oe && !reset_line_n_o));
endmodule

// >>> test/wrs_top_sva.sv
// Assertions on the reset wire, watchdog mode and status reads.
// Assumes binding to wrs_top; sees its ports only.
`timescale 1ns/10ps
module wrs_top_sva #(
	parameter int SHORT_RST_CYC = 8,
	parameter int LONG_RST_CYC  = 16
) (
	input wire logic        ref_clk,
	input wire logic        arst_n,
	input wire logic        reg_wr,
	input wire logic        reg_rd,
	input wire logic [2:0]  reg_addr_bits,
	input wire logic [15:0] reg_wdata,
	input wire logic [15:0] reg_rdata,
	input wire logic [1:0]  chip_mode_code,
	input wire logic        overtemp_mode,
	input wire logic        sleep_req,
	input wire logic        sleep_grant,
	input wire logic        wd_disable_pin,
	input wire logic        fail_safe_output_ctrl,
	input wire logic        irq_line_n,
	input wire logic        reset_line_n_i,
	input wire logic        reset_line_n_o,
	input wire logic        reset_line_n_oe,
	input wire logic        sys_reset_pulse,
	input wire logic        fail_safe_en,
	input wire logic [1:0]  wd_mode_state
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!arst_n);
	logic        idle;
	logic [23:0] oe_len_r;
	assign idle = !reset_line_n_oe && reset_line_n_i;
	// Length of the current drive phase
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n)
			oe_len_r <= 24'h00_0000;
		else if (reset_line_n_oe)
			oe_len_r <= oe_len_r + 24'h00_0001;
		else
			oe_len_r <= 24'h00_0000;
	end
	property p_low; reset_line_n_oe |-> !reset_line_n_o; endproperty
	a_low: assert property (p_low) else $error("wire driven high");
	property p_soft;
		reg_wr && reg_addr_bits == 3'h0 && reg_wdata[4] && idle |-> sys_reset_pulse ##1 reset_line_n_oe;
	endproperty
	a_soft: assert property (p_soft) else $error("soft reset lost");
	property p_len; $fell(reset_line_n_oe) |-> oe_len_r == SHORT_RST_CYC || oe_len_r == LONG_RST_CYC; endproperty
	a_len: assert property (p_len) else $error("bad pulse width");
	property p_en; fail_safe_en |-> fail_safe_output_ctrl && chip_mode_code[1]; endproperty
	a_en: assert property (p_en) else $error("enable out of mode");
	property p_en_rst; sys_reset_pulse |=> !fail_safe_en; endproperty
	a_en_rst: assert property (p_en_rst) else $error("enable after reset");
	property p_win; wd_mode_state == 2'h1 |-> $past(chip_mode_code[1] && !wd_disable_pin && !overtemp_mode); endproperty
	a_win: assert property (p_win) else $error("window mode wrong");
	property p_off; wd_mode_state != 2'h0 |-> $past(!wd_disable_pin && chip_mode_code != 2'h1); endproperty
	a_off: assert property (p_off) else $error("watchdog not off");
	property p_grant; sleep_grant |-> $past(sleep_req && irq_line_n); endproperty
	a_grant: assert property (p_grant) else $error("bad sleep grant");
	property p_refuse; sleep_req && !irq_line_n && idle |-> sys_reset_pulse ##1 !sleep_grant; endproperty
	a_refuse: assert property (p_refuse) else $error("sleep not refused");
	property p_addr;
		reg_rd && reg_addr_bits == 3'h3 |=> reg_rdata[15:13] == 3'h3 && reg_rdata[9:8] == 2'h0 && reg_rdata[2:0] == 3'h0;
	endproperty
	a_addr: assert property (p_addr) else $error("status frame wrong");
	c_soft: cover property (sys_reset_pulse ##1 reset_line_n_oe);
	c_win: cover property (wd_mode_state == 2'h1);
	c_grant: cover property (sleep_grant);
	c_long: cover property ($fell(reset_line_n_oe) && oe_len_r == LONG_RST_CYC);
endmodule
bind wrs_top wrs_top_sva #(
	.SHORT_RST_CYC (SHORT_RST_CYC),
	.LONG_RST_CYC  (LONG_RST_CYC)
) u_sva (
	.ref_clk               (ref_clk),
	.arst_n                (arst_n),
	.reg_wr                (reg_wr),
	.reg_rd                (reg_rd),
	.reg_addr_bits         (reg_addr_bits),
	.reg_wdata             (reg_wdata),
	.reg_rdata             (reg_rdata),
	.chip_mode_code        (chip_mode_code),
	.overtemp_mode         (overtemp_mode),
	.sleep_req             (sleep_req),
	.sleep_grant           (sleep_grant),
	.wd_disable_pin        (wd_disable_pin),
	.fail_safe_output_ctrl (fail_safe_output_ctrl),
	.irq_line_n            (irq_line_n),
	.reset_line_n_i        (reset_line_n_i),
	.reset_line_n_o        (reset_line_n_o),
	.reset_line_n_oe       (reset_line_n_oe),
	.sys_reset_pulse       (sys_reset_pulse),
	.fail_safe_en          (fail_safe_en),
	.wd_mode_state         (wd_mode_state)
);

// >>> test/wrs_top_tb_top.sv
// Self-checking bench of the watchdog, reset and status block.
// Assumes the reset wire partner model and the bound checker.
`timescale 1ns/10ps
module wrs_top_tb_top;
	logic        ref_clk, arst_n, reg_wr, reg_rd, sleep_req, osc_tick, hold_req, fsc, clp, irqn, dis;
	logic        e_ml, e_cl, e_w1, e_w2, e_bw, e_uv, strap, wire_n, oe, o, pulse, fse, grant, ot, e_mx, lk;
	logic [2:0]  addr;
	logic [15:0] wdata, rdata;
	logic [1:0]  mc, c1, c2, wms;
	int          errors = 0, comparisons = 0, pulses = 0, ep = 0, st, seed = 32'h9dca_1771;
	wrs_top #(.SHORT_RST_CYC(8), .LONG_RST_CYC(16)) DUT (
		.ref_clk(ref_clk), .arst_n(arst_n), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr_bits(addr),
		.reg_wdata(wdata), .reg_rdata(rdata), .chip_mode_code(mc), .overtemp_mode(ot), .sleep_req(sleep_req),
		.sleep_grant(grant), .wd_disable_pin(dis), .fail_safe_output_ctrl(fsc), .can_lowpower_ctrl(clp),
		.wake1_irq_cfg(c1), .wake2_irq_cfg(c2), .irq_line_n(irqn), .main_low_evt(e_ml), .can_low_evt(e_cl),
		.wake1_evt(e_w1), .wake2_evt(e_w2), .bus_wake_evt(e_bw), .main_uv_rst_evt(e_uv),
		.mode_exit_rst_evt(e_mx), .osc_tick(osc_tick), .short_rst_strap(strap), .reset_line_n_i(wire_n),
		.reset_line_n_o(o), .reset_line_n_oe(oe), .sys_reset_pulse(pulse), .fail_safe_en(fse),
		.wd_mode_state(wms)
	);
	wrs_mcu_model u_mcu (.reset_line_n_o(o), .reset_line_n_oe(oe), .hold_req(hold_req), .wire_n(wire_n));
	initial begin
		ref_clk = 1'b0;
		forever #12.5 ref_clk = ~ref_clk;
	end
	always @(posedge ref_clk)
		if (arst_n && pulse === 1'b1)
			pulses <= pulses + 1;
	task automatic summarize;
		$display("errors=%0d comparisons=%0d", errors, comparisons);
		if (errors == 0 && comparisons > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		comparisons++;
		if (got !== exp) begin
			errors++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [2:0] a, input logic [15:0] d);
		@(posedge ref_clk);
		addr <= a;
		wdata <= d;
		reg_wr <= 1'b1;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
		// Flag model: ones clear unless the lock stood before this write
		if (a == 3'h3) begin
			if (!lk)
				st &= ~(int'(d) & 32'h0000_0cf8);
			lk = d[12];
		end
	endtask
	// Status reads are judged against the flag model st
	task automatic rd(input logic [2:0] a);
		@(posedge ref_clk);
		addr <= a;
		reg_rd <= 1'b1;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		@(negedge ref_clk);
		chk(rdata, (a == 3'h3) ? (16'h6000 | 16'(st) | {3'h0, lk, 12'h000}) : 16'h0000);
	endtask
	task automatic tick(input int n);
		repeat (n) begin
			@(posedge ref_clk);
			osc_tick <= 1'b1;
			@(posedge ref_clk);
			osc_tick <= 1'b0;
			repeat (2) @(posedge ref_clk);
		end
	endtask
	// Checks the running count of system resets, then lets the reset wire recover
	task automatic pz(input int n);
		repeat (2) @(negedge ref_clk);
		ep += n;
		chk(16'(pulses), 16'(ep));
		repeat (24) @(posedge ref_clk);
	endtask
	task automatic slp(input logic g);
		@(posedge ref_clk);
		sleep_req <= 1'b1;
		@(posedge ref_clk);
		sleep_req <= 1'b0;
		@(negedge ref_clk);
		chk({15'h0, grant}, {15'h0, g});
	endtask
	initial begin
		{arst_n, reg_wr, reg_rd, sleep_req, osc_tick, hold_req, fsc, dis, e_ml, e_cl, e_w1, e_w2, e_bw, e_uv, strap} = '0;
		{ot, e_mx, lk} = '0;
		{addr, wdata, mc} = '0;
		{irqn, clp, c1, c2} = 6'h37;
		st = 16'h0020;
		repeat (3) @(posedge ref_clk);
		arst_n <= 1'b1;
		rd(3'h3);
		rd(3'h5);
		wr(3'h3, 16'($random(seed)) & 16'he307);
		rd(3'h3);
		wr(3'h3, 16'h0020);
		rd(3'h3);
		@(posedge ref_clk);
		{e_ml, e_cl, e_w1, e_w2, e_bw} <= 5'h1f;
		@(posedge ref_clk);
		{e_ml, e_cl, e_w1, e_w2, e_bw} <= 5'h00;
		st |= 32'h0000_0c58;
		rd(3'h3);
		wr(3'h3, 16'h0408);
		rd(3'h3);
		wr(3'h3, 16'h0c58);
		@(negedge ref_clk);
		chk({14'h0, wms}, 16'h0002);
		// Standby: select bit turns the watchdog off, a pending flag brings it back
		wr(3'h0, 16'h0100);
		repeat (2) @(negedge ref_clk);
		chk({14'h0, wms}, 16'h0000);
		@(posedge ref_clk);
		e_w2 <= 1'b1;
		@(posedge ref_clk);
		e_w2 <= 1'b0;
		st |= 32'h0000_0010;
		repeat (2) @(negedge ref_clk);
		chk({14'h0, wms}, 16'h0002);
		wr(3'h0, 16'h0000);
		wr(3'h3, 16'h0010);
		repeat (2) @(negedge ref_clk);
		chk({14'h0, wms}, 16'h0000);
		wr(3'h0, 16'h0000);
		@(posedge ref_clk);
		ot <= 1'b1;
		repeat (2) @(negedge ref_clk);
		chk({14'h0, wms}, 16'h0000);
		@(posedge ref_clk);
		ot <= 1'b0;
		wr(3'h0, 16'h0000);
		tick(9);
		st |= 32'h0000_0080;
		rd(3'h3);
		wr(3'h3, 16'h1000);
		rd(3'h3);
		wr(3'h3, 16'h0080);
		rd(3'h3);
		tick(9);
		pz(1);
		wr(3'h3, 16'h0080);
		tick(120);
		rd(3'h3);
		tick(10);
		st |= 32'h0000_0080;
		rd(3'h3);
		wr(3'h3, 16'h0080);
		wr(3'h0, 16'h0000);
		mc <= 2'h2;
		repeat (2) @(negedge ref_clk);
		chk({14'h0, wms}, 16'h0001);
		tick(6);
		wr(3'h0, 16'h0000);
		pz(0);
		tick(2);
		wr(3'h0, 16'h0000);
		pz(1);
		tick(130);
		pz(1);
		@(posedge ref_clk);
		fsc <= 1'b1;
		repeat (2) @(negedge ref_clk);
		chk({15'h0, fse}, 16'h0001);
		@(posedge ref_clk);
		dis <= 1'b1;
		pz(1);
		@(negedge ref_clk);
		chk({15'h0, fse}, 16'h0000);
		chk({14'h0, wms}, 16'h0000);
		// Watchdog is off here, so only the soft reset bit can cause this one
		wr(3'h0, 16'h0010);
		pz(1);
		@(posedge ref_clk);
		fsc <= 1'b0;
		for (int i = 0; i < 2; i++) begin
			@(posedge ref_clk);
			hold_req <= 1'b1;
			repeat (20 + 25 * i) @(posedge ref_clk);
			hold_req <= 1'b0;
			pz(i);
		end
		@(posedge ref_clk);
		e_uv <= 1'b1;
		@(posedge ref_clk);
		e_uv <= 1'b0;
		pz(1);
		@(posedge ref_clk);
		e_mx <= 1'b1;
		@(posedge ref_clk);
		e_mx <= 1'b0;
		st |= 32'h0000_0020;
		pz(1);
		rd(3'h3);
		slp(1'b1);
		for (int i = 0; i < 3; i++) begin
			@(posedge ref_clk);
			irqn <= (i != 0);
			{clp, c1, c2} <= (i == 1) ? 5'h00 : 5'h1f;
			e_w1 <= (i == 2);
			@(posedge ref_clk);
			e_w1 <= 1'b0;
			slp(1'b0);
			pz(1);
		end
		summarize();
	end
	initial begin
		#500000;
		errors++;
		summarize();
	end
endmodule
